/* File: verilog/kde_pkg.sv */
package kde_pkg;

    // apb register map, byte addresses
    localparam logic [7:0] KDE_CTRL_OFF     = 8'h00;
    localparam logic [7:0] KDE_DIGIT_LO_OFF = 8'h04;
    localparam logic [7:0] KDE_DIGIT_HI_OFF = 8'h08;
    localparam logic [7:0] KDE_KEYIND_OFF   = 8'h0C;
    localparam logic [7:0] KDE_STATUS_OFF   = 8'h10;
    localparam logic [7:0] KDE_COUNT_OFF    = 8'h14;

    // control fields
    localparam int KDE_CTRL_EN_BIT    = 0;
    localparam int KDE_CTRL_HEX_BIT   = 1;
    localparam int KDE_CTRL_CLEAR_BIT = 2;

    // status fields
    localparam int KDE_STAT_WORD_LSB  = 0;
    localparam int KDE_STAT_FAULT_BIT = 8;
    localparam int KDE_STAT_HELD_BIT  = 9;

    // reset values
    localparam logic [1:0]  KDE_CTRL_RST   = 2'h0;
    localparam logic [31:0] KDE_DIGIT_RST  = 32'h0000_0000;
    localparam logic [15:0] KDE_KEYIND_RST = 16'h0000;
    localparam logic [3:0]  KDE_COUNT_RST  = 4'h0;

    // keypad geometry
    localparam int KDE_DEC_KEYS    = 10;
    localparam int KDE_ANY_KEY_BIT = 10;
    localparam int KDE_DIGITS      = 8;
    localparam int KDE_PIN_W       = 16;
    localparam int KDE_HEX_LINES   = 4;

    // scan cycle timing
    localparam int KDE_CLK_NS       = 20;
    localparam int KDE_SCAN_TICK_NS = 1_000_000;
    localparam int KDE_SCAN_TICK_CYC = KDE_SCAN_TICK_NS / KDE_CLK_NS;

    typedef enum logic [0:0] {
        KDE_HS_SELECT,
        KDE_HS_HOLD
    } kde_hex_state_type;

    // shift one digit into the low end, oldest digit drops out
    function automatic logic [31:0] kde_shift_digit(input logic [31:0] s, input logic [3:0] d);
        return {s[27:0], d};
    endfunction

    function automatic logic [15:0] kde_onehot16(input logic [3:0] k);
        return 16'h0001 << k;
    endfunction

    // lowest set bit index of a 4-bit line group
    function automatic logic [1:0] kde_low4(input logic [3:0] v);
        return v[0] ? 2'd0 : v[1] ? 2'd1 : v[2] ? 2'd2 : 2'd3;
    endfunction

endpackage

/* File: verilog/kde_scan_if.sv */
`timescale 1ns/100ps
interface kde_scan_if;
    logic       tick;
    logic       restart;
    logic       active;
    logic [3:0] data;
    logic [3:0] sel;
    logic       key_stb;
    logic [3:0] key_code;
    logic       held;
    logic [7:0] state_word;

    modport scanner (
        input  tick, restart, active, data,
        output sel, key_stb, key_code, held, state_word
    );
    modport host (
        output tick, restart, active, data,
        input  sel, key_stb, key_code, held, state_word
    );
endinterface

/* File: verilog/kde_hex_scan.sv */
`timescale 1ns/100ps
module kde_hex_scan
    import kde_pkg::*;
(
    // clock and reset
    input wire logic      pclk,
    input wire logic      presetn,
    // link to the entry logic
    kde_scan_if.scanner   sif
);

    kde_hex_state_type st_r;
    logic [1:0]        row_r;
    logic [1:0]        col_r;
    logic [3:0]        sel_r;
    logic              stb_r;
    logic [3:0]        code_r;

    wire       step      = sif.tick & sif.active;
    wire       hit       = |sif.data;
    wire [1:0] hit_col   = kde_low4(sif.data);
    wire       released  = ~sif.data[col_r];
    wire [1:0] row_inc   = row_r + 2'd1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r   <= KDE_HS_SELECT;
            row_r  <= 2'd0;
            col_r  <= 2'd0;
            sel_r  <= 4'h0;
            stb_r  <= 1'b0;
            code_r <= 4'h0;
        end else begin
            stb_r <= 1'b0;
            if (!sif.active) begin
                sel_r <= 4'h0;
            end else if (sif.restart && sif.tick) begin
                st_r  <= KDE_HS_SELECT;
                row_r <= 2'd0;
                sel_r <= 4'h1;
            end else if (step) begin
                case (st_r)
                    KDE_HS_SELECT: begin
                        if (hit && sel_r != 4'h0) begin
                            // key = line * 4 + data bit
                            code_r <= {row_r, hit_col};
                            col_r  <= hit_col;
                            stb_r  <= 1'b1;
                            st_r   <= KDE_HS_HOLD;
                        end else begin
                            row_r <= row_inc;
                            sel_r <= 4'h1 << row_inc;
                        end
                    end
                    KDE_HS_HOLD: begin
                        // other keys are masked until this one lets go
                        if (released) begin
                            st_r  <= KDE_HS_SELECT;
                            row_r <= 2'd0;
                            sel_r <= 4'h1;
                        end
                    end
                    default: st_r <= KDE_HS_SELECT;
                endcase
            end
        end
    end

    assign sif.sel        = sel_r;
    assign sif.key_stb    = stb_r;
    assign sif.key_code   = code_r;
    assign sif.held       = (st_r == KDE_HS_HOLD);
    assign sif.state_word = {3'b000, st_r == KDE_HS_HOLD, col_r, row_r};

endmodule

/* File: verilog/kde_keypad_entry.sv */
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module kde_keypad_entry
    import kde_pkg::*;
#(
    parameter int SCAN_TICK_CYCLES = KDE_SCAN_TICK_CYC
)(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // keypad pins
    input  wire logic [15:0] key_in,
    output logic      [3:0]  sel_out
);

    kde_scan_if sif ();

    // pin synchronisers
    logic [KDE_PIN_W-1:0] key_meta_r;
    logic [KDE_PIN_W-1:0] key_sync_r;

    // scan cycle divider
    logic [31:0] tick_cnt_r;
    logic        tick_r;

    // software visible state, plus the pending restart flag
    logic [1:0]  ctrl_r;
    logic        restart_pend_r;
    logic [31:0] dstore_r;
    logic [15:0] keyind_r;
    logic [3:0]  count_r;

    // ten-key lock
    logic        tk_locked_r;
    logic [3:0]  tk_idx_r;

    // apb answer
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;

    //------------------------------------------------------------
    // input pins pass two flops before anything looks at them
    //------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_meta_r <= 16'h0000;
            key_sync_r <= 16'h0000;
        end else begin
            key_meta_r <= key_in;
            key_sync_r <= key_meta_r;
        end
    end

    //------------------------------------------------------------
    // one pulse per scan cycle
    //------------------------------------------------------------
    wire tick_wrap = (tick_cnt_r == 32'(SCAN_TICK_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r     <= 1'b0;
        end else begin
            tick_cnt_r <= tick_wrap ? 32'h0000_0000 : tick_cnt_r + 32'd1;
            tick_r     <= tick_wrap;
        end
    end

    //------------------------------------------------------------
    // apb decode
    //------------------------------------------------------------
    wire acc_phase  = psel & penable;
    wire acc_done   = acc_phase & pready_r;
    wire wr_done    = acc_done & pwrite;
    wire hit_ctrl   = (paddr == KDE_CTRL_OFF);
    wire hit_lo     = (paddr == KDE_DIGIT_LO_OFF);
    wire hit_hi     = (paddr == KDE_DIGIT_HI_OFF);
    wire hit_ind    = (paddr == KDE_KEYIND_OFF);
    wire hit_stat   = (paddr == KDE_STATUS_OFF);
    wire hit_cnt    = (paddr == KDE_COUNT_OFF);
    wire mapped     = hit_ctrl | hit_lo | hit_hi | hit_ind | hit_stat | hit_cnt;
    wire wr_ctrl    = wr_done & hit_ctrl;
    wire wr_lo      = wr_done & hit_lo;
    wire wr_hi      = wr_done & hit_hi;
    wire wr_ind     = wr_done & hit_ind;
    wire wr_clear   = wr_ctrl & pwdata[KDE_CTRL_CLEAR_BIT];

    //------------------------------------------------------------
    // mode control
    //------------------------------------------------------------
    wire       run_en   = ctrl_r[KDE_CTRL_EN_BIT];
    wire       hex_mode = ctrl_r[KDE_CTRL_HEX_BIT];
    wire       new_en   = pwdata[KDE_CTRL_EN_BIT];
    wire       new_hex  = pwdata[KDE_CTRL_HEX_BIT];
    // any start or mode swap restarts the active entry from scratch
    wire       start_req = wr_ctrl & new_en & (~run_en | (new_hex != hex_mode));
    wire       tk_run    = run_en & ~hex_mode;
    wire       hx_run    = run_en & hex_mode;
    wire       tk_tick   = tk_run & tick_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= KDE_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= {new_hex, new_en};
        end
    end

    // a new start request wins over the tick that consumes an older one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_pend_r <= 1'b0;
        end else if (start_req) begin
            restart_pend_r <= 1'b1;
        end else if (tick_r) begin
            restart_pend_r <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // ten-key entry
    //------------------------------------------------------------
    wire [KDE_DEC_KEYS-1:0] dec_keys = key_sync_r[KDE_DEC_KEYS-1:0];
    wire                    dec_any  = |dec_keys;
    logic [3:0]             dec_low;

    always_comb begin
        dec_low = 4'h0;
        for (int i = KDE_DEC_KEYS - 1; i >= 0; i--) begin
            if (dec_keys[i]) begin
                dec_low = 4'(i);
            end
        end
    end

    // a restart drops any old lock so the first cycle samples afresh
    wire tk_locked  = tk_locked_r & ~restart_pend_r;
    wire tk_accept  = tk_tick & ~tk_locked & dec_any;
    // only the locked key can release the lock
    wire tk_release = tk_tick & tk_locked & ~dec_keys[tk_idx_r];

    // lock is the only ten-key state beside store, indicator and count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tk_locked_r <= 1'b0;
            tk_idx_r    <= 4'h0;
        end else if (!tk_run) begin
            tk_locked_r <= 1'b0;
        end else if (tk_accept) begin
            tk_locked_r <= 1'b1;
            tk_idx_r    <= dec_low;
        end else if (tk_release || (tk_tick && restart_pend_r)) begin
            tk_locked_r <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // hexadecimal entry
    //------------------------------------------------------------
    assign sif.tick    = tick_r;
    assign sif.restart = restart_pend_r;
    assign sif.active  = hx_run;
    assign sif.data    = key_sync_r[KDE_HEX_LINES-1:0];

    kde_hex_scan u_scan (
        .pclk    (pclk),
        .presetn (presetn),
        .sif     (sif)
    );

    wire hx_accept = hx_run & sif.key_stb;

    //------------------------------------------------------------
    // digit store: hardware shift wins over a software write
    //------------------------------------------------------------
    logic [31:0] dstore_nxt;

    always_comb begin
        dstore_nxt = dstore_r;
        if (tk_accept) begin
            dstore_nxt = kde_shift_digit(dstore_r, dec_low);
        end else if (hx_accept) begin
            dstore_nxt = kde_shift_digit(dstore_r, sif.key_code);
        end else if (wr_clear) begin
            dstore_nxt = KDE_DIGIT_RST;
        end else if (wr_lo) begin
            dstore_nxt = {dstore_r[31:16], pwdata[15:0]};
        end else if (wr_hi) begin
            dstore_nxt = {pwdata[15:0], dstore_r[15:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dstore_r <= KDE_DIGIT_RST;
        end else begin
            dstore_r <= dstore_nxt;
        end
    end

    // digits entered since clear, stops at the store depth
    wire cnt_full = (count_r == 4'(KDE_DIGITS));
    wire key_in_accept = tk_accept | hx_accept;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= KDE_COUNT_RST;
        end else if (key_in_accept) begin
            count_r <= cnt_full ? count_r : count_r + 4'd1;
        end else if (wr_clear) begin
            count_r <= KDE_COUNT_RST;
        end
    end

    //------------------------------------------------------------
    // key indicator word
    //------------------------------------------------------------
    logic [15:0] keyind_nxt;

    always_comb begin
        keyind_nxt = keyind_r;
        if (wr_ind) begin
            keyind_nxt = pwdata[15:0];
        end
        if (wr_clear) begin
            keyind_nxt = KDE_KEYIND_RST;
        end
        if (tk_accept) begin
            keyind_nxt[KDE_DEC_KEYS-1:0] = KDE_DEC_KEYS'(kde_onehot16(dec_low));
        end
        if (tk_tick) begin
            keyind_nxt[KDE_ANY_KEY_BIT] = dec_any;
        end
        if (hx_accept) begin
            keyind_nxt = kde_onehot16(sif.key_code);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keyind_r <= KDE_KEYIND_RST;
        end else begin
            keyind_r <= keyind_nxt;
        end
    end

    //------------------------------------------------------------
    // read mux and apb answer, one wait state on every access
    //------------------------------------------------------------
    // fault flag never rises: it is tied low, an unmapped access is answered only with pslverr
    wire        fault_flag = 1'b0;
    wire        held_now   = hex_mode ? sif.held : tk_locked_r;
    // scanner word is readable only, so nothing outside can disturb it
    wire [31:0] stat_word  = {22'h00_0000, held_now, fault_flag, sif.state_word};
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (1'b1)
            hit_ctrl: rd_mux = {30'h0000_0000, ctrl_r};
            hit_lo:   rd_mux = {16'h0000, dstore_r[15:0]};
            hit_hi:   rd_mux = {16'h0000, dstore_r[31:16]};
            hit_ind:  rd_mux = {16'h0000, keyind_r};
            hit_stat: rd_mux = stat_word;
            hit_cnt:  rd_mux = {28'h000_0000, count_r};
            default:  rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= acc_phase & ~pready_r;
            pslverr_r <= acc_phase & ~pready_r & ~mapped;
            if (acc_phase && !pready_r && !pwrite) begin
                prdata_r <= rd_mux;
            end
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign sel_out = sif.sel;

endmodule

/* File: verification/kde_keypad_model.sv */
`timescale 1ns/100ps
module kde_keypad_model
    import kde_pkg::*;
(
    // switches closed by the bench
    input  wire logic        hex_mode,
    input  wire logic [15:0] dec_keys,
    input  wire logic        hex_down,
    input  wire logic [3:0]  hex_key,
    // keypad pins
    input  wire logic [3:0]  sel_out,
    output logic      [15:0] key_in
);
    // hex key code is row in the upper pair, data line in the lower pair
    wire logic [3:0] hex_line = 4'h1 << hex_key[1:0];
    wire logic       row_on   = hex_down && sel_out[hex_key[3:2]];

    // open switches read at the pull-down level; contacts settle well inside one scan cycle
    assign key_in = hex_mode ? {12'h000, row_on ? hex_line : 4'h0} : dec_keys;
endmodule

/* File: verification/kde_keypad_entry_asserts.sv */
`timescale 1ns/100ps
module kde_keypad_entry_asserts
    import kde_pkg::*;
#(
    parameter int SCAN_TICK_CYCLES = KDE_SCAN_TICK_CYC
)(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // keypad pins
    input wire logic [15:0] key_in,
    input wire logic [3:0]  sel_out
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [3:0]  sel_prev_r;
    logic [31:0] dwell_r;
    wire  logic  sel_moved = (sel_out != sel_prev_r) && (sel_out != 4'h0);

    // dwell counts edges since the select lines last changed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_prev_r <= 4'h0;
            dwell_r    <= 32'h0000_0000;
        end else begin
            sel_prev_r <= sel_out;
            dwell_r    <= (sel_out != sel_prev_r) ? 32'h0000_0000 : dwell_r + 32'h0000_0001;
        end
    end

    chk_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not exactly one wait state");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    chk_err_reads_zero: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0000_0000))
        else $error("pslverr without pready or nonzero data");
    chk_sel_onehot: assert property ($onehot0(sel_out))
        else $error("several select lines high");
    chk_sel_ascend: assert property (sel_moved && sel_prev_r != 4'h0 |->
        sel_out == {sel_prev_r[2:0], sel_prev_r[3]} || sel_out == 4'h1)
        else $error("select lines out of order");
    chk_sel_first_row: assert property (sel_moved && sel_prev_r == 4'h0 |-> sel_out == 4'h1)
        else $error("scan did not start on first line");
    chk_sel_dwell: assert property (sel_moved && sel_prev_r != 4'h0 |-> dwell_r >= SCAN_TICK_CYCLES - 1)
        else $error("select stepped faster than scan tick");

    cover property (sel_out == 4'h8);
    cover property (pready && pslverr);
    cover property (pready && !pwrite && prdata != 32'h0000_0000);
endmodule

bind kde_keypad_entry kde_keypad_entry_asserts #(.SCAN_TICK_CYCLES(SCAN_TICK_CYCLES)) i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_in(key_in), .sel_out(sel_out)
);

/* File: verification/tb.sv */
`timescale 1ns/100ps
module tb;
    import kde_pkg::*;
    localparam int TICK = 8;
    logic        pclk     = 1'b0;
    logic        presetn  = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] key_in;
    logic [3:0]  sel_out;
    logic        hex_mode = 1'b0;
    logic [15:0] dec_keys = 16'h0000;
    logic        hex_down = 1'b0;
    logic [3:0]  hex_key  = 4'h0;
    logic [31:0] exp_store;
    int          fails    = 0;
    int          checked  = 0;

    always #10 pclk = ~pclk;

    kde_keypad_entry #(.SCAN_TICK_CYCLES(TICK)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .key_in(key_in), .sel_out(sel_out)
    );
    kde_keypad_model i_pad (
        .hex_mode(hex_mode), .dec_keys(dec_keys), .hex_down(hex_down), .hex_key(hex_key),
        .sel_out(sel_out), .key_in(key_in)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge pclk);
            n++;
        end
        if (n == 16) begin
            fails++;
            $display("MISMATCH pready exp 1 seen timeout");
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so a following call never reassigns psel in this step
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        check(what, q, exp);
        check("pslverr", {31'h0, e}, {31'h0, experr});
    endtask

    task automatic ticks(input int n);
        repeat (n * TICK) @(posedge pclk);
    endtask

    task automatic t_reset();
        logic [31:0] q;
        logic        e;
        rd_chk("ctrl", KDE_CTRL_OFF, 32'h0000_0000, 1'b0);
        rd_chk("lo", KDE_DIGIT_LO_OFF, 32'h0000_0000, 1'b0);
        rd_chk("hi", KDE_DIGIT_HI_OFF, 32'h0000_0000, 1'b0);
        rd_chk("keyind", KDE_KEYIND_OFF, 32'h0000_0000, 1'b0);
        rd_chk("count", KDE_COUNT_OFF, 32'h0000_0000, 1'b0);
        rd_chk("status", KDE_STATUS_OFF, 32'h0000_0000, 1'b0);
        wr(KDE_DIGIT_LO_OFF, 32'hFFFF_ABCD);
        wr(KDE_DIGIT_HI_OFF, 32'h0000_1234);
        wr(KDE_KEYIND_OFF, 32'h0000_0208);
        rd_chk("lo wr", KDE_DIGIT_LO_OFF, 32'h0000_ABCD, 1'b0);
        rd_chk("hi wr", KDE_DIGIT_HI_OFF, 32'h0000_1234, 1'b0);
        rd_chk("keyind wr", KDE_KEYIND_OFF, 32'h0000_0208, 1'b0);
        // clear bit empties store and indicator but is not kept in ctrl
        wr(KDE_CTRL_OFF, 32'h0000_0004);
        rd_chk("ctrl clr", KDE_CTRL_OFF, 32'h0000_0000, 1'b0);
        rd_chk("lo clr", KDE_DIGIT_LO_OFF, 32'h0000_0000, 1'b0);
        rd_chk("hi clr", KDE_DIGIT_HI_OFF, 32'h0000_0000, 1'b0);
        rd_chk("keyind clr", KDE_KEYIND_OFF, 32'h0000_0000, 1'b0);
        rd_chk("unmapped rd", 8'h18, 32'h0000_0000, 1'b1);
        apb(1'b1, 8'h20, 32'hFFFF_FFFF, q, e);
        check("unmapped wr", {31'h0, e}, 32'h0000_0001);
        $display("t_reset done");
    endtask

    // keys 1..9 then 0: ten digits, so the two oldest fall off the top
    task automatic t_decimal();
        int d;
        exp_store = 32'h0000_0000;
        wr(KDE_CTRL_OFF, 32'h0000_0001);
        for (int k = 1; k <= 10; k++) begin
            d = k % 10;
            dec_keys <= 16'h0001 << d;
            ticks(4);
            exp_store = {exp_store[27:0], d[3:0]};
            rd_chk("dec held", KDE_KEYIND_OFF, 32'h0000_0400 | (32'h0000_0001 << d), 1'b0);
            dec_keys <= 16'h0000;
            ticks(4);
            rd_chk("dec free", KDE_KEYIND_OFF, 32'h0000_0001 << d, 1'b0);
            rd_chk("dec lo", KDE_DIGIT_LO_OFF, {16'h0000, exp_store[15:0]}, 1'b0);
            rd_chk("dec hi", KDE_DIGIT_HI_OFF, {16'h0000, exp_store[31:16]}, 1'b0);
        end
        rd_chk("count", KDE_COUNT_OFF, 32'h0000_0008, 1'b0);
        check("sel tenkey", {28'h000_0000, sel_out}, 32'h0000_0000);
        $display("t_decimal done");
    endtask

    // a lower key joins while 7 is held; the lowest-first pick must not take it
    task automatic t_lock();
        dec_keys <= 16'h0080;
        ticks(3);
        dec_keys <= 16'h0084;
        ticks(3);
        exp_store = {exp_store[27:0], 4'h7};
        rd_chk("lock ind", KDE_KEYIND_OFF, 32'h0000_0480, 1'b0);
        rd_chk("lock lo", KDE_DIGIT_LO_OFF, {16'h0000, exp_store[15:0]}, 1'b0);
        // status is read only: a write must not disturb the scanner word
        wr(KDE_STATUS_OFF, 32'hFFFF_FFFF);
        rd_chk("lock stat", KDE_STATUS_OFF, 32'h0000_0200, 1'b0);
        dec_keys <= 16'h0000;
        ticks(3);
        $display("t_lock done");
    endtask

    task automatic t_hex();
        exp_store = 32'h0000_0000;
        hex_mode <= 1'b1;
        wr(KDE_CTRL_OFF, 32'h0000_0007);
        for (int k = 0; k < 16; k++) begin
            hex_key  <= k[3:0];
            hex_down <= 1'b1;
            ticks(6);
            exp_store = {exp_store[27:0], k[3:0]};
            rd_chk("hex ind", KDE_KEYIND_OFF, 32'h0000_0001 << k, 1'b0);
            hex_down <= 1'b0;
            ticks(3);
            rd_chk("hex kept", KDE_KEYIND_OFF, 32'h0000_0001 << k, 1'b0);
            rd_chk("hex lo", KDE_DIGIT_LO_OFF, {16'h0000, exp_store[15:0]}, 1'b0);
        end
        rd_chk("hex hi", KDE_DIGIT_HI_OFF, {16'h0000, exp_store[31:16]}, 1'b0);
        $display("t_hex done");
    endtask

    task automatic t_restart();
        int n;
        ticks(2);
        wr(KDE_CTRL_OFF, 32'h0000_0000);
        ticks(2);
        check("sel off", {28'h000_0000, sel_out}, 32'h0000_0000);
        wr(KDE_CTRL_OFF, 32'h0000_0003);
        n = 0;
        while (sel_out === 4'h0 && n < 4 * TICK) begin
            @(posedge pclk);
            n++;
        end
        check("sel first", {28'h000_0000, sel_out}, 32'h0000_0001);
        $display("t_restart done");
    endtask

    task automatic wrap_up();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_decimal();
        t_lock();
        t_hex();
        t_restart();
        wrap_up();
    end

    // whole run needs about 2400 cycles
    initial begin
        #(20 * 30000);
        fails++;
        $display("MISMATCH watchdog exp done seen hang");
        wrap_up();
    end
endmodule
